//--- src/temp_readout_consts.vh
// Constants for the serial temperature readout block
// Assumes a 25 MHz system clock; included by the readout design file only
`ifndef TEMP_READOUT_CONSTS_VH
`define TEMP_READOUT_CONSTS_VH

`define CLK_HZ 25000000
`define SLOW_PERIOD_MS 8000
`define FAST_PERIOD_MS 500
`define CONV_TIME_MS 250
`define SLOW_PERIOD_CYC ((`CLK_HZ / 1000) * `SLOW_PERIOD_MS)
`define FAST_PERIOD_CYC ((`CLK_HZ / 1000) * `FAST_PERIOD_MS)
`define CONV_TIME_CYC ((`CLK_HZ / 1000) * `CONV_TIME_MS)
`define RESULT_W 13
`define FRAME_W 16
`define RESULT_RST 13'h0000
`define CONFIRM_POS 2
`define BITCNT_W 5

`endif

//--- src/sync2.v
// Two-flop synchroniser for one asynchronous level
// Assumes the input is from outside the I_CLK domain
`timescale 1ns/1ps
`default_nettype none
module sync2 (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_rst_val,
  input wire i_async,
  output wire o_sync
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge i_clk) begin
    if (!i_reset_n) begin
      meta_reg <= i_rst_val;
      sync_reg <= i_rst_val;
    end else begin
      meta_reg <= i_async;
      sync_reg <= meta_reg;
    end
  end

  // Reset level is the pin's idle level, tied at the instance
  assign o_sync = sync_reg;
endmodule
`default_nettype wire

//--- src/temp_sensor_serial_readout.v
// Serial readout and conversion sequencing of a temperature sensor
// Assumes select and serial clock come from an outside host; the
// converter front end hands a 13-bit sample on completion
// Partial frames are legal; the host must then let a conversion
// finish before the next read, nothing here enforces that
`timescale 1ns/1ps
`default_nettype none
`include "temp_readout_consts.vh"
module temp_sensor_serial_readout #(
  parameter SLOW_VARIANT = 1'b0,
  parameter [31:0] SLOW_PERIOD_CYC = `SLOW_PERIOD_CYC,
  parameter [31:0] FAST_PERIOD_CYC = `FAST_PERIOD_CYC,
  parameter [31:0] CONV_TIME_CYC = `CONV_TIME_CYC
) (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_CS_N,
  input wire I_SCK,
  input wire [`RESULT_W-1:0] I_ADC_SAMPLE,
  output reg O_SO,
  output reg O_SO_OE,
  output reg O_CONVERTING,
  output reg O_CONV_START,
  output reg [`RESULT_W-1:0] O_RESULT
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Count down one, stopping at zero
  function [31:0] dec_sat;
    input [31:0] val;
    begin
      if (val != 32'h00000000)
        dec_sat = val - 32'h00000001;
      else
        dec_sat = 32'h00000000;
    end
  endfunction

  // Falling edge of a synchronised level
  function fell_edge;
    input now_val;
    input prev_val;
    begin
      fell_edge = ~now_val & prev_val;
    end
  endfunction

  // Rising edge of a synchronised level
  function rose_edge;
    input now_val;
    input prev_val;
    begin
      rose_edge = now_val & ~prev_val;
    end
  endfunction

  // Counter in its last cycle
  function at_end;
    input [31:0] val;
    begin
      at_end = (val <= 32'h00000001);
    end
  endfunction

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  wire cs_n_s;
  wire sck_s;
  // Select idles high
  sync2 u_cs_sync (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_rst_val(1'b1),
    .i_async(I_CS_N),
    .o_sync(cs_n_s)
  );
  // Serial clock idles low
  sync2 u_sck_sync (
    .i_clk(I_CLK),
    .i_reset_n(I_RESET_N),
    .i_rst_val(1'b0),
    .i_async(I_SCK),
    .o_sync(sck_s)
  );

  // Previous levels for edge finding; reset to each pin's idle level
  reg cs_prev_reg;
  reg sck_prev_reg;
  wire cs_rise = rose_edge(cs_n_s, cs_prev_reg);
  wire cs_fall = fell_edge(cs_n_s, cs_prev_reg);
  wire sck_fall = fell_edge(sck_s, sck_prev_reg);

  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      cs_prev_reg <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_n_s;
      sck_prev_reg <= sck_s;
    end
  end

  // ------------------------------------------------------------
  // Conversion sequencer
  // ------------------------------------------------------------
  // One-hot states
  localparam [2:0] ST_WAIT = 3'b001;
  localparam [2:0] ST_CONV = 3'b010;
  localparam [2:0] ST_IDLE = 3'b100;

  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [31:0] conv_cnt_reg;
  reg [31:0] conv_cnt_next;
  reg [31:0] period_cnt_reg;
  reg [31:0] period_cnt_next;
  reg [`RESULT_W-1:0] result_next;
  reg start_next;
  wire [31:0] period_cyc = SLOW_VARIANT ? SLOW_PERIOD_CYC : FAST_PERIOD_CYC;

  always @* begin
    state_next = state_reg;
    conv_cnt_next = conv_cnt_reg;
    period_cnt_next = period_cnt_reg;
    result_next = O_RESULT;
    start_next = 1'b0;
    case (state_reg)
      ST_WAIT: begin
        period_cnt_next = dec_sat(period_cnt_reg);
        if (!cs_n_s) begin
          state_next = ST_IDLE;
        end else if (at_end(period_cnt_reg)) begin
          state_next = ST_CONV;
          conv_cnt_next = CONV_TIME_CYC;
          period_cnt_next = period_cyc;
          start_next = 1'b1;
        end
      end
      ST_CONV: begin
        period_cnt_next = dec_sat(period_cnt_reg);
        // Abort leaves the last result untouched
        if (!cs_n_s) begin
          state_next = ST_IDLE;
        end else if (at_end(conv_cnt_reg)) begin
          result_next = I_ADC_SAMPLE;
          state_next = ST_WAIT;
        end else begin
          conv_cnt_next = dec_sat(conv_cnt_reg);
        end
      end
      // Select held low: result stays, shifter keeps serving
      ST_IDLE: begin
        if (cs_rise) begin
          state_next = ST_CONV;
          conv_cnt_next = CONV_TIME_CYC;
          period_cnt_next = period_cyc;
          start_next = 1'b1;
        end
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      state_reg <= ST_WAIT;
      conv_cnt_reg <= 32'h00000000;
      period_cnt_reg <= 32'h00000000;
      O_RESULT <= `RESULT_RST;
      O_CONV_START <= 1'b0;
      O_CONVERTING <= 1'b0;
    end else begin
      state_reg <= state_next;
      conv_cnt_reg <= conv_cnt_next;
      period_cnt_reg <= period_cnt_next;
      O_RESULT <= result_next;
      O_CONV_START <= start_next;
      O_CONVERTING <= (state_next == ST_CONV);
    end
  end

  // ------------------------------------------------------------
  // Serial output shifter
  // ------------------------------------------------------------
  reg [`FRAME_W-1:0] shift_reg;
  reg [`BITCNT_W-1:0] bit_cnt_reg;

  always @(posedge I_CLK) begin
    if (!I_RESET_N) begin
      shift_reg <= {`FRAME_W{1'b0}};
      bit_cnt_reg <= {`BITCNT_W{1'b0}};
      O_SO <= 1'b0;
      O_SO_OE <= 1'b0;
    end else if (cs_n_s) begin
      bit_cnt_reg <= {`BITCNT_W{1'b0}};
      O_SO_OE <= 1'b0;
      O_SO <= 1'b0;
    end else if (cs_fall) begin
      // Result on top, confirm bit low, two undriven tail bits
      shift_reg <= {O_RESULT, 3'b000};
      O_SO <= O_RESULT[`RESULT_W-1];
      O_SO_OE <= 1'b1;
      bit_cnt_reg <= 5'h01;
    end else if (sck_fall && bit_cnt_reg != 5'h00) begin
      // Shifting works in idle as well
      shift_reg <= {shift_reg[`FRAME_W-2:0], 1'b0};
      O_SO <= shift_reg[`FRAME_W-2];
      // Counter stops at sixteen so extra clocks stay quiet
      if (bit_cnt_reg < 5'h10)
        bit_cnt_reg <= bit_cnt_reg + 5'h01;
      O_SO_OE <= (bit_cnt_reg < (`FRAME_W - `CONFIRM_POS));
    end
  end
endmodule
`default_nettype wire

//--- testbench/readout_chk_asserts.sv
// Port checker for the temperature readout
// Bound to the readout top; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module readout_chk #(
  parameter [31:0] FAST_PERIOD_CYC = 100,
  parameter [31:0] CONV_TIME_CYC = 20
) (
  input wire I_CLK,
  input wire I_RESET_N,
  input wire I_CS_N,
  input wire I_SCK,
  input wire O_SO,
  input wire O_SO_OE,
  input wire O_CONVERTING,
  input wire O_CONV_START,
  input wire [12:0] O_RESULT
);
  // ----
  // Checks
  // ----
  localparam int PMAX = FAST_PERIOD_CYC + CONV_TIME_CYC + 8;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RESET_N);
  a_reset_quiet: assert property (
    disable iff (1'b0) !I_RESET_N |=> !O_SO_OE && O_RESULT == 13'h0000) else $error("reset");
  a_rise_start: assert property (
    $rose(I_CS_N) |-> ##[1:6] O_CONV_START) else $error("no start");
  a_rise_release: assert property (
    $rose(I_CS_N) |-> ##[1:6] !O_SO_OE) else $error("still driving");
  a_fall_drive: assert property (
    $fell(I_CS_N) |-> ##[1:6] O_SO_OE) else $error("no drive");
  a_sck_hold: assert property (
    $rose(I_SCK) |=> $stable(O_SO)[*4]) else $error("data moved");
  a_period_start: assert property (
    O_CONV_START |-> ##[1:PMAX] (O_CONV_START || !I_CS_N)) else $error("period");
  a_boot_start: assert property (
    $rose(I_RESET_N) |-> ##[0:8] O_CONV_START) else $error("boot");
  a_result_cause: assert property (
    $changed(O_RESULT) |-> $past(O_CONVERTING)) else $error("result");
  c_start: cover property (O_CONV_START);
  c_tail: cover property ($fell(O_SO_OE) && !I_CS_N);
  c_result: cover property ($changed(O_RESULT));
endmodule
bind temp_sensor_serial_readout readout_chk #(.FAST_PERIOD_CYC(FAST_PERIOD_CYC),
  .CONV_TIME_CYC(CONV_TIME_CYC)) i_readout_chk (.I_CLK(I_CLK), .I_RESET_N(I_RESET_N),
  .I_CS_N(I_CS_N), .I_SCK(I_SCK), .O_SO(O_SO), .O_SO_OE(O_SO_OE),
  .O_CONVERTING(O_CONVERTING), .O_CONV_START(O_CONV_START), .O_RESULT(O_RESULT));
`default_nettype wire

//--- testbench/spi_host_model.sv
// Host model: select and serial clock, 320 ns period
// Started by i_go at a falling system clock edge
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic i_go,
  input wire logic [4:0] i_bits,
  input wire logic i_so,
  input wire logic i_oe,
  output logic o_cs_n,
  output logic o_sck,
  output logic o_busy,
  output logic [15:0] o_word,
  output logic [1:0] o_tail_oe
);
  // ----
  // Frame read
  // ----
  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_busy = 1'b0;
  end
  always @(posedge i_go) begin
    o_busy = 1'b1;
    o_cs_n = 1'b0;
    for (int k = 0; k < i_bits; k++) begin
      #160 o_sck = 1'b1;
      o_word = {o_word[14:0], i_so};
      o_tail_oe = {o_tail_oe[0], i_oe};
      #160 o_sck = 1'b0;
    end
    #160 o_cs_n = 1'b1;
    #40 o_busy = 1'b0;
  end
endmodule
`default_nettype wire

//--- testbench/temp_sensor_serial_readout_tb.sv
// Bench for the temperature readout
// Host model reads frames; short period counts
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_serial_readout_tb;
  logic clk, rst_n, go, cs_n, sck, so, oe, busy;
  logic [4:0] bits;
  logic [12:0] sample;
  logic [15:0] word;
  logic [1:0] tail;
  logic [31:0] r;
  logic [13:0] exp_q[$];
  integer seed = 45848;
  int err_total = 0;
  int checks_done = 0;
  temp_sensor_serial_readout #(.SLOW_PERIOD_CYC(200), .FAST_PERIOD_CYC(100),
    .CONV_TIME_CYC(20)) i_temp_sensor_serial_readout (.I_CLK(clk), .I_RESET_N(rst_n),
    .I_CS_N(cs_n), .I_SCK(sck), .I_ADC_SAMPLE(sample), .O_SO(so), .O_SO_OE(oe),
    .O_CONVERTING(), .O_CONV_START(), .O_RESULT());
  spi_host_model i_spi_host_model (.i_go(go), .i_bits(bits), .i_so(so), .i_oe(oe),
    .o_cs_n(cs_n), .o_sck(sck), .o_busy(busy), .o_word(word), .o_tail_oe(tail));
  // ----
  // Clock, checks, sequence
  // ----
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(negedge busy) begin
    if (bits == 5'h10 && exp_q.size() > 0) begin
      chk({word[15:2], 2'h0}, {exp_q.pop_front(), 2'h0});
      chk({14'h0000, tail}, 16'h0000);
    end
  end
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    bits = 5'h10;
    sample = 13'h0000;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    for (int i = 0; i < 8; i++) begin
      r = $random(seed);
      sample = r[12:0];
      repeat (60) @(negedge clk);
      bits = (i == 3) ? 5'h05 : 5'h10;
      if (i != 3) exp_q.push_back({sample, 1'b0});
      go = 1'b1;
      @(negedge clk);
      go = 1'b0;
      wait (!busy);
      @(negedge clk);
    end
    stop_test();
  end
  initial begin
    #200000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
